// file: common/orr_pkg.sv
package orr_pkg;

  // bus and datapath widths
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned PC_W    = 13;

  // register offsets (byte addresses)
  localparam logic [11:0] OFS_INSTR  = 12'h000;
  localparam logic [11:0] OFS_ACC    = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_PC     = 12'h00c;
  localparam logic [11:0] OFS_STACK  = 12'h010;
  localparam logic [11:0] OFS_FILE   = 12'h200;
  localparam logic [2:0]  FILE_TAG   = 3'h1;

  // status and stack field positions
  localparam int unsigned ST_ZERO_BIT  = 0;
  localparam int unsigned ST_CARRY_BIT = 1;
  localparam int unsigned ST_GIE_BIT   = 2;
  localparam int unsigned ST_BAD_BIT   = 3;
  localparam int unsigned STK_PTR_LSB  = 16;

  // reset values
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST  = 13'h0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // opcode masks and match values
  localparam logic [13:0] MSK_OR_LIT   = 14'h3f00;
  localparam logic [13:0] VAL_OR_LIT   = 14'h3800;
  localparam logic [13:0] MSK_LOAD_LIT = 14'h3c00;
  localparam logic [13:0] VAL_LOAD_LIT = 14'h3000;
  localparam logic [13:0] MSK_OR_REG   = 14'h3f00;
  localparam logic [13:0] VAL_OR_REG   = 14'h0400;
  localparam logic [13:0] MSK_STORE    = 14'h3f80;
  localparam logic [13:0] VAL_STORE    = 14'h0080;
  localparam logic [13:0] MSK_COPY     = 14'h3f00;
  localparam logic [13:0] VAL_COPY     = 14'h0800;
  localparam logic [13:0] MSK_ROTATE   = 14'h3f00;
  localparam logic [13:0] VAL_ROTATE   = 14'h0d00;
  localparam logic [13:0] MSK_NOP      = 14'h3f9f;
  localparam logic [13:0] VAL_NOP      = 14'h0000;
  localparam logic [13:0] VAL_RET_IRQ  = 14'h0009;

  // operand fields
  localparam int unsigned DEST_BIT = 7;

  // decoded operation
  typedef enum logic [3:0] {
    OP_NO_OPERATION,
    OP_OR_LITERAL,
    OP_LOAD_LITERAL,
    OP_OR_REGISTER,
    OP_STORE_ACCUMULATOR,
    OP_COPY_REGISTER,
    OP_ROTATE_LEFT_CARRY,
    OP_RETURN_INTERRUPT,
    OP_ILLEGAL
  } orr_op_t;

  // status flags carried together
  typedef struct packed {
    logic bad_op;
    logic global_irq_enable;
    logic carry;
    logic zero;
  } orr_status_t;

endpackage : orr_pkg

// file: core/orr_exec.sv
`timescale 1ns/1ps
module orr_exec
  import orr_pkg::*;
#(
  parameter int unsigned FILE_DEPTH  = 128,
  parameter int unsigned STACK_DEPTH = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  // write data channel
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  // write response channel
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  // read data channel
  output      logic [DATA_W-1:0] s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  localparam int unsigned SP_W = $clog2(STACK_DEPTH);

  // core state
  logic [INSTR_W-1:0] instr_reg;
  logic [7:0]         acc_reg, acc_next;
  logic [PC_W-1:0]    pc_reg, pc_next;
  orr_status_t        st_reg, st_next;
  logic [7:0]         file_mem [FILE_DEPTH];
  logic [PC_W-1:0]    stack_mem [STACK_DEPTH];
  logic [SP_W-1:0]    sp_reg;
  logic [SP_W:0]      fill_reg;

  // bus slave state
  logic              aw_full_reg, w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg, rvalid_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic [DATA_W-1:0] rdata_reg;

  // handshakes
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire wr_go   = aw_full_reg & w_full_reg & ~bvalid_reg;

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // write address decode
  wire wa_instr  = aw_addr_reg == OFS_INSTR;
  wire wa_acc    = aw_addr_reg == OFS_ACC;
  wire wa_status = aw_addr_reg == OFS_STATUS;
  wire wa_pc     = aw_addr_reg == OFS_PC;
  wire wa_stack  = aw_addr_reg == OFS_STACK;
  wire wa_file   = (aw_addr_reg[11:9] == FILE_TAG)
                   & (aw_addr_reg[1:0] == 2'b00);
  wire wa_hit    = wa_instr | wa_acc | wa_status | wa_pc | wa_stack | wa_file;
  wire [6:0] wa_idx = aw_addr_reg[8:2];

  // read address decode
  wire [6:0] ra_idx  = s_axi_araddr[8:2];
  wire ra_file = (s_axi_araddr[11:9] == FILE_TAG)
                 & (s_axi_araddr[1:0] == 2'b00);
  wire ra_hit  = ra_file | (s_axi_araddr == OFS_INSTR)
                 | (s_axi_araddr == OFS_ACC) | (s_axi_araddr == OFS_STATUS)
                 | (s_axi_araddr == OFS_PC) | (s_axi_araddr == OFS_STACK);

  // read view of one register
  function automatic logic [DATA_W-1:0] reg_view(
    input logic [ADDR_W-1:0] a,
    input logic [7:0]        fval
  );
    logic [DATA_W-1:0] v;
    v = '0;
    if (a[11:9] == FILE_TAG) begin
      v[7:0] = fval;
    end else begin
      case (a)
        OFS_INSTR:  v[INSTR_W-1:0] = instr_reg;
        OFS_ACC:    v[7:0] = acc_reg;
        OFS_STATUS: v[3:0] = st_reg;
        OFS_PC:     v[PC_W-1:0] = pc_reg;
        OFS_STACK: begin
          v[PC_W-1:0] = stack_mem[sp_reg];
          v[STK_PTR_LSB +: SP_W+1] = fill_reg;
        end
        default:    v = '0;
      endcase
    end
    return v;
  endfunction : reg_view

  // byte-lane merge of a bus write into the current value
  logic [DATA_W-1:0] w_old, w_val;
  assign w_old = reg_view(aw_addr_reg, file_mem[wa_idx]);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      w_val[8*i +: 8] = w_strb_reg[i] ? w_data_reg[8*i +: 8]
                                      : w_old[8*i +: 8];
    end
  end

  // instruction fields
  wire [INSTR_W-1:0] op_word = w_data_reg[INSTR_W-1:0];
  wire [7:0]         lit     = op_word[7:0];
  wire [6:0]         f_idx   = op_word[6:0];
  wire               to_file = op_word[DEST_BIT];
  wire [7:0]         f_val   = file_mem[f_idx];
  wire               exec    = wr_go & wa_instr;

  // opcode decode; load_literal ignores bits 9:8
  orr_op_t op;
  assign op =
    ((op_word & MSK_OR_LIT) == VAL_OR_LIT)     ? OP_OR_LITERAL :
    ((op_word & MSK_LOAD_LIT) == VAL_LOAD_LIT) ? OP_LOAD_LITERAL :
    ((op_word & MSK_OR_REG) == VAL_OR_REG)     ? OP_OR_REGISTER :
    ((op_word & MSK_STORE) == VAL_STORE)       ? OP_STORE_ACCUMULATOR :
    ((op_word & MSK_COPY) == VAL_COPY)         ? OP_COPY_REGISTER :
    ((op_word & MSK_ROTATE) == VAL_ROTATE)     ? OP_ROTATE_LEFT_CARRY :
    (op_word == VAL_RET_IRQ)                   ? OP_RETURN_INTERRUPT :
    ((op_word & MSK_NOP) == VAL_NOP)           ? OP_NO_OPERATION :
                                                 OP_ILLEGAL;

  // execution and register write next-state
  logic       f_we;
  logic [6:0] f_wa;
  logic [7:0] f_wd;
  logic [7:0] res;
  logic       pop, push;
  always_comb begin
    acc_next = acc_reg;
    st_next  = st_reg;
    pc_next  = pc_reg;
    f_we     = 1'b0;
    f_wa     = f_idx;
    f_wd     = '0;
    res      = '0;
    pop      = 1'b0;
    push     = 1'b0;
    if (exec) begin
      pc_next = pc_reg + 1'b1;
      case (op)
        OP_OR_LITERAL: begin
          res          = acc_reg | lit;
          acc_next     = res;
          st_next.zero = (res == 8'h00);
        end
        OP_LOAD_LITERAL: begin
          acc_next = lit;
        end
        OP_OR_REGISTER: begin
          res          = acc_reg | f_val;
          st_next.zero = (res == 8'h00);
        end
        OP_STORE_ACCUMULATOR: begin
          f_we = 1'b1;
          f_wd = acc_reg;
        end
        OP_COPY_REGISTER: begin
          res          = f_val;
          st_next.zero = (res == 8'h00);
        end
        OP_ROTATE_LEFT_CARRY: begin
          res           = {f_val[6:0], st_reg.carry};
          st_next.carry = f_val[7];
        end
        OP_RETURN_INTERRUPT: begin
          pc_next                   = stack_mem[sp_reg];
          st_next.global_irq_enable = 1'b1;
          pop                       = 1'b1;
        end
        OP_NO_OPERATION: begin
          pc_next = pc_reg + 1'b1;
        end
        default: begin
          st_next.bad_op = 1'b1;
        end
      endcase
      // destination select for register-operand results
      if (op == OP_OR_REGISTER || op == OP_COPY_REGISTER
          || op == OP_ROTATE_LEFT_CARRY) begin
        if (to_file) begin
          f_we = 1'b1;
          f_wd = res;
        end else begin
          acc_next = res;
        end
      end
    end else if (wr_go && wa_hit) begin
      if (wa_acc) begin
        acc_next = w_val[7:0];
      end
      if (wa_pc) begin
        pc_next = w_val[PC_W-1:0];
      end
      if (wa_status) begin
        st_next.zero              = w_val[ST_ZERO_BIT];
        st_next.carry             = w_val[ST_CARRY_BIT];
        st_next.global_irq_enable = w_val[ST_GIE_BIT];
        if (w_val[ST_BAD_BIT]) begin
          st_next.bad_op = 1'b0;                 // write one to clear
        end
      end
      if (wa_file) begin
        f_we = 1'b1;
        f_wa = wa_idx;
        f_wd = w_val[7:0];
      end
      push = wa_stack;
    end
  end

  // core registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_reg <= '0;
      acc_reg   <= ACC_RST;
      pc_reg    <= PC_RST;
      st_reg    <= '0;
    end else begin
      if (exec) begin
        instr_reg <= op_word;
      end
      acc_reg <= acc_next;
      pc_reg  <= pc_next;
      st_reg  <= st_next;
    end
  end

  // file register array
  always_ff @(posedge clk) begin
    if (f_we) begin
      file_mem[f_wa] <= f_wd;
    end
  end

  // return stack; wraps when pushed past its depth
  always_ff @(posedge clk) begin
    if (push) begin
      stack_mem[sp_reg + 1'b1] <= w_data_reg[PC_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_reg   <= '0;
      fill_reg <= '0;
    end else if (push) begin
      sp_reg   <= sp_reg + 1'b1;
      fill_reg <= (fill_reg == (SP_W+1)'(STACK_DEPTH)) ? fill_reg
                                                       : fill_reg + 1'b1;
    end else if (pop) begin
      sp_reg   <= sp_reg - 1'b1;
      fill_reg <= (fill_reg == '0) ? fill_reg : fill_reg - 1'b1;
    end
  end

  // write channel capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_reg <= 1'b0;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wa_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= ra_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= ra_hit ? reg_view(s_axi_araddr, file_mem[ra_idx]) : '0;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : orr_exec

// file: verification/orr_exec_checker.sv
`timescale 1ns/1ps
module orr_exec_checker
  import orr_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // write channels
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  // read channels
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // bus handshakes and hold rules
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data not held");
  a_rd_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read valid stuck");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_rd_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == '0) else $error("error read data not zero");
  a_wr_latency: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing wrong");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp not held");
  a_wr_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write valid stuck");
  a_wr_block: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("write address taken while held");
  a_wd_block: assert property (s_axi_wvalid && s_axi_wready |=>
    !s_axi_wready) else $error("write data taken while held");
  a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY ||
    s_axi_bresp == RESP_SLVERR) else $error("bad write resp code");

  // main scenarios
  c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_rd_done: cover property (s_axi_rvalid && s_axi_rready);
  c_wr_both: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid);
endmodule : orr_exec_checker

bind orr_exec orr_exec_checker u_chk (
  .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// file: verification/orr_tb.sv
`timescale 1ns/1ps
module tb
  import orr_pkg::*;
;
  // one executed instruction and the state it should leave
  typedef struct packed {
    logic [13:0] ins;
    logic [7:0]  acc;
    logic [7:0]  fil;
    logic [3:0]  st;
    logic [7:0]  e_acc;
    logic [7:0]  e_fil;
    logic [3:0]  e_st;
  } orr_row_t;
  localparam orr_row_t ROWS [13] = '{
    '{14'h38f0, 8'h0f, 8'h00, 4'h1, 8'hff, 8'h00, 4'h0},
    '{14'h3800, 8'h00, 8'h5a, 4'h6, 8'h00, 8'h5a, 4'h7},
    '{14'h305a, 8'h11, 8'h00, 4'h3, 8'h5a, 8'h00, 4'h3},
    '{14'h3300, 8'hff, 8'h22, 4'h0, 8'h00, 8'h22, 4'h0},
    '{14'h0405, 8'h30, 8'h03, 4'h1, 8'h33, 8'h03, 4'h0},
    '{14'h04ff, 8'h30, 8'h0c, 4'h0, 8'h30, 8'h3c, 4'h0},
    '{14'h0481, 8'h00, 8'h00, 4'h2, 8'h00, 8'h00, 4'h3},
    '{14'h00ff, 8'ha5, 8'h00, 4'h3, 8'ha5, 8'ha5, 4'h3},
    '{14'h0882, 8'h11, 8'h00, 4'h0, 8'h11, 8'h00, 4'h1},
    '{14'h0803, 8'h11, 8'h80, 4'h1, 8'h80, 8'h80, 4'h0},
    '{14'h0d04, 8'h00, 8'h81, 4'h2, 8'h03, 8'h81, 4'h2},
    '{14'h0d87, 8'h55, 8'hff, 4'h1, 8'h55, 8'hfe, 4'h3},
    '{14'h0060, 8'h12, 8'h34, 4'h5, 8'h12, 8'h34, 4'h5}};
  // bench signals
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_valid;
  logic              aw_ready;
  logic [DATA_W-1:0] w_data;
  logic              w_valid;
  logic              w_ready;
  logic [1:0]        b_resp;
  logic              b_valid;
  logic              b_ready;
  logic [ADDR_W-1:0] ar_addr;
  logic              ar_valid;
  logic              ar_ready;
  logic [DATA_W-1:0] r_data;
  logic [1:0]        r_resp;
  logic              r_valid;
  logic              r_ready;
  logic [DATA_W-1:0] d;
  logic [1:0]        rs;
  int                num_errors;
  int                check_count;

  orr_exec DUT (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(aw_addr),
    .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
    .s_axi_wdata(w_data), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_valid),
    .s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
    .s_axi_bready(b_ready), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
    .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_valid), .s_axi_rready(r_ready)
  );

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // write: both halves offered together, released as taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic done;
    done = 1'b0;
    aw_addr  <= a;
    aw_valid <= 1'b1;
    w_data   <= v;
    w_valid  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_valid) done = 1'b1;
      rs = b_resp;
    end
  endtask : wr

  // read: address held until taken, data at rvalid edge
  task automatic rd(input logic [11:0] a);
    logic done;
    done = 1'b0;
    ar_addr  <= a;
    ar_valid <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
      if (r_valid) done = 1'b1;
      d  = r_data;
      rs = r_resp;
    end
  endtask : rd

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  function automatic logic [11:0] fa(input logic [6:0] n);
    return OFS_FILE + {3'h0, n, 2'b00};
  endfunction : fa

  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report();
  end

  initial begin
    num_errors  = 0;
    check_count = 0;
    rst_n    <= 1'b0;
    aw_addr  <= '0;
    aw_valid <= 1'b0;
    w_data   <= '0;
    w_valid  <= 1'b0;
    ar_addr  <= '0;
    ar_valid <= 1'b0;
    b_ready  <= 1'b1;
    r_ready  <= 1'b1;
    repeat (3) @(posedge clk);
    chk("arready_rst", 32'h1, {31'h0, ar_ready});
    chk("bvalid_rst", 32'h0, {31'h0, b_valid});
    rst_n <= 1'b1;
    rd(OFS_ACC);
    chk("acc_rst", 32'h0, d);
    rd(OFS_STATUS);
    chk("status_rst", 32'h0, d);
    // table of instructions
    foreach (ROWS[i]) begin
      wr(OFS_ACC, {24'h0, ROWS[i].acc});
      wr(fa(ROWS[i].ins[6:0]), {24'h0, ROWS[i].fil});
      wr(OFS_STATUS, {28'h0, ROWS[i].st});
      wr(OFS_INSTR, {18'h0, ROWS[i].ins});
      rd(OFS_ACC);
      chk("acc", {24'h0, ROWS[i].e_acc}, d);
      rd(fa(ROWS[i].ins[6:0]));
      chk("file", {24'h0, ROWS[i].e_fil}, d);
      rd(OFS_STATUS);
      chk("status", {28'h0, ROWS[i].e_st}, d);
    end
    // unmapped place, answers held while ready is low
    b_ready <= 1'b0;
    r_ready <= 1'b0;
    wr(12'h100, 32'hffff_ffff);
    chk("wr_resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    repeat (2) @(posedge clk);
    chk("bvalid_hold", 32'h1, {31'h0, b_valid});
    chk("bresp_hold", {30'h0, RESP_SLVERR}, {30'h0, b_resp});
    b_ready <= 1'b1;
    rd(12'h100);
    chk("rd_resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    chk("rd_unmapped", 32'h0, d);
    repeat (2) @(posedge clk);
    chk("rvalid_hold", 32'h1, {31'h0, r_valid});
    chk("rdata_hold", 32'h0, r_data);
    r_ready <= 1'b1;
    @(posedge clk);
    // return from interrupt
    wr(OFS_STACK, 32'h0000_0123);
    rd(OFS_STACK);
    chk("stack_top", 32'h0001_0123, d);
    wr(OFS_STATUS, 32'h0000_0003);
    wr(OFS_INSTR, 32'h0000_0009);
    rd(OFS_PC);
    chk("pc_ret", 32'h0000_0123, d);
    rd(OFS_STATUS);
    chk("status_ret", 32'h0000_0007, d);
    // unknown instruction then clear
    wr(OFS_INSTR, 32'h0000_3fff);
    rd(OFS_STATUS);
    chk("bad_op", 32'h0000_000f, d);
    rd(OFS_PC);
    chk("pc_step", 32'h0000_0124, d);
    wr(OFS_PC, 32'h0000_0055);
    rd(OFS_PC);
    chk("pc_write", 32'h0000_0055, d);
    wr(OFS_STATUS, 32'h0000_0008);
    rd(OFS_STATUS);
    chk("bad_clr", 32'h0, d);
    // reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_PC);
    chk("pc_rst2", 32'h0, d);
    final_report();
  end
endmodule : tb
